// *** desi_error_irq.sv ***
`timescale 1ns/1ps
`include "desi_params.svh"
// sticky error status and interrupt pin for the two receive channels
module desi_error_irq (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register port: byte address, write strobe, read strobe
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output desi_pkg::desi_byte_t o_reg_rdata,
    output logic o_reg_rvalid,
    // channel A error pulses
    input wire logic i_a_sync_err,
    input wire logic i_a_crc_err,
    input wire logic i_a_unc_ecc_err,
    input wire logic i_a_cor_ecc_err,
    input wire desi_pkg::desi_llp_t i_a_llp_err,
    input wire logic i_a_leader_err,
    // channel B error pulses
    input wire logic i_b_sync_err,
    input wire logic i_b_crc_err,
    input wire logic i_b_unc_ecc_err,
    input wire logic i_b_cor_ecc_err,
    input wire desi_pkg::desi_llp_t i_b_llp_err,
    input wire logic i_b_leader_err,
    // synthesizer lock level
    input wire logic i_pll_locked,
    // interrupt pin, driven only while enabled
    output logic o_irq,
    output logic o_irq_oe
);
    import desi_pkg::*;

    desi_byte_t irq_ctrl;
    desi_byte_t a_enable;
    desi_byte_t b_enable;
    desi_byte_t a_status;
    desi_byte_t b_status;
    desi_byte_t a_set;
    desi_byte_t b_set;
    desi_byte_t next_rdata;
    logic lock_prev;
    logic wr_a_status;
    logic wr_b_status;
    logic next_irq;

    // any of the six classes counts as one protocol error
    function automatic logic llp_any(input desi_llp_t cls);
        llp_any = |cls;
    endfunction

    // gather set pulses per status bit
    always_comb begin
        a_set = 8'h00;
        a_set[`DESI_BIT_SYNC] = i_a_sync_err;
        a_set[`DESI_BIT_CRC] = i_a_crc_err;
        a_set[`DESI_BIT_UNC] = i_a_unc_ecc_err;
        a_set[`DESI_BIT_COR] = i_a_cor_ecc_err;
        a_set[`DESI_BIT_LLP] = llp_any(i_a_llp_err);
        a_set[`DESI_BIT_SOT] = i_a_leader_err;
        a_set[`DESI_BIT_UNLOCK] = lock_prev & ~i_pll_locked;
        b_set = 8'h00;
        b_set[`DESI_BIT_SYNC] = i_b_sync_err;
        b_set[`DESI_BIT_CRC] = i_b_crc_err;
        b_set[`DESI_BIT_UNC] = i_b_unc_ecc_err;
        b_set[`DESI_BIT_COR] = i_b_cor_ecc_err;
        b_set[`DESI_BIT_LLP] = llp_any(i_b_llp_err);
        b_set[`DESI_BIT_SOT] = i_b_leader_err;
    end

    // previous lock level; starts locked-low so power-up gives no spurious edge
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= i_pll_locked;
        end
    end

    assign wr_a_status = i_reg_wr && (i_reg_addr == `DESI_ADDR_A_STATUS);
    assign wr_b_status = i_reg_wr && (i_reg_addr == `DESI_ADDR_B_STATUS);

    desi_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(`DESI_RST_A_STATUS),
        .IMPL_MASK(`DESI_A_STATUS_MASK)
    ) u_a_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_set(a_set),
        .i_clr_we(wr_a_status),
        .i_clr_data(i_reg_wdata),
        .o_flags(a_status)
    );

    desi_flag_bank #(
        .WIDTH(8),
        .RESET_VALUE(`DESI_RST_B_STATUS),
        .IMPL_MASK(`DESI_B_STATUS_MASK)
    ) u_b_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_set(b_set),
        .i_clr_we(wr_b_status),
        .i_clr_data(i_reg_wdata),
        .o_flags(b_status)
    );

    // control and enable registers; unused bits stay zero
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_ctrl <= `DESI_RST_ENABLE;
            a_enable <= `DESI_RST_ENABLE;
            b_enable <= `DESI_RST_ENABLE;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `DESI_ADDR_IRQ_CTRL: begin
                    irq_ctrl <= i_reg_wdata & 8'h01;
                end
                `DESI_ADDR_A_ENABLE: begin
                    a_enable <= i_reg_wdata & `DESI_A_STATUS_MASK;
                end
                `DESI_ADDR_B_ENABLE: begin
                    b_enable <= i_reg_wdata & `DESI_B_STATUS_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (i_reg_addr)
            `DESI_ADDR_IRQ_CTRL: next_rdata = irq_ctrl;
            `DESI_ADDR_A_ENABLE: next_rdata = a_enable;
            `DESI_ADDR_B_ENABLE: next_rdata = b_enable;
            `DESI_ADDR_A_STATUS: next_rdata = a_status;
            `DESI_ADDR_B_STATUS: next_rdata = b_status;
            default: next_rdata = 8'h00;
        endcase
    end

    // registered read data, one cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // masked flags; registered, so the pin lags a flag by one cycle
    assign next_irq = |(a_status & a_enable) | |(b_status & b_enable);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
            o_irq_oe <= 1'b0;
        end else begin
            o_irq_oe <= irq_ctrl[`DESI_BIT_GLOBAL_EN];
            o_irq <= irq_ctrl[`DESI_BIT_GLOBAL_EN] & next_irq;
        end
    end
endmodule

// *** desi_params.svh ***
// Function
// - a channel A low-level protocol error report sets bit 3 of the channel A status register.
// - each channel's low-level protocol flag is set by start/end sync, escape entry, low-power sync, false control and lane merge errors.
// - a channel A leader sequence bit error report sets bit 2 of the channel A status register.
// - a locked-to-unlocked change of the synthesizer lock sets bit 0 of channel A status, which resets to 1.
// - an unexpected sync packet on channel B sets bit 7 of the channel B status register.
// - a channel B payload check error sets bit 6 of the channel B status register.
// - a channel B uncorrectable header error sets bit 5 of the channel B status register.
// - a channel B corrected header error sets bit 4 of the channel B status register.
// - any channel B low-level protocol error class sets bit 3 of the channel B status register.
// - a channel B leader sequence bit error sets bit 2 of the channel B status register.
// - every flag holds until the host writes 1 to its bit, and all but lock-loss reset to 0.
// - with the global enable set the interrupt is driven high while any enabled flag is set.
// - with the global enable clear, its reset state, the interrupt pin is not driven.
// - every error has its own enable bit, reset 0, that masks it from the interrupt while clear.
// - channel A sync, payload check, uncorrectable and corrected header flags sit at bits 7 to 4.
`ifndef DESI_PARAMS_SVH
`define DESI_PARAMS_SVH
`define DESI_ADDR_IRQ_CTRL 8'hE0
`define DESI_ADDR_A_ENABLE 8'hE1
`define DESI_ADDR_B_ENABLE 8'hE2
`define DESI_ADDR_A_STATUS 8'hE5
`define DESI_ADDR_B_STATUS 8'hE6
`define DESI_BIT_SYNC 7
`define DESI_BIT_CRC 6
`define DESI_BIT_UNC 5
`define DESI_BIT_COR 4
`define DESI_BIT_LLP 3
`define DESI_BIT_SOT 2
`define DESI_BIT_UNLOCK 0
`define DESI_BIT_GLOBAL_EN 0
`define DESI_RST_A_STATUS 8'h01
`define DESI_RST_B_STATUS 8'h00
`define DESI_RST_ENABLE 8'h00
`define DESI_A_STATUS_MASK 8'hFD
`define DESI_B_STATUS_MASK 8'hFC
`define DESI_LLP_CLASSES 6
`endif

// *** desi_pkg.sv ***
package desi_pkg;
    typedef logic [7:0] desi_byte_t;
    // one bit per low-level protocol error class
    typedef logic [5:0] desi_llp_t;
endpackage

// *** desi_flag_bank.sv ***
`timescale 1ns/1ps
`include "desi_params.svh"
// bank of write-one-to-clear sticky flags
module desi_flag_bank #(
    parameter int WIDTH = 8,
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_clr_we,
    input wire logic [WIDTH-1:0] i_clr_data,
    output logic [WIDTH-1:0] o_flags
);
    initial begin
        if (WIDTH != 8) $error("desi_flag_bank: width must be 8");
    end

    // set beats clear so a coincident event is never lost
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flags <= RESET_VALUE;
        end else begin
            o_flags <= ((o_flags & ~({WIDTH{i_clr_we}} & i_clr_data)) | i_set)
                & IMPL_MASK;
        end
    end
endmodule

// *** desi_host_model.sv ***
`timescale 1ns/1ps
// host end of the interrupt pin
module desi_host_model (
    input wire logic i_irq,
    input wire logic i_irq_oe,
    output logic o_pin
);
    // a released pin falls to the board pull-down, never the last value
    assign o_pin = i_irq_oe ? i_irq : 1'b0;
endmodule

// *** desi_error_irq_props.sv ***
`timescale 1ns/1ps
// port-level checks of the sticky flags and the interrupt pin
module desi_error_irq_props (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire desi_pkg::desi_byte_t o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_b_sync_err,
    input wire logic i_b_crc_err,
    input wire logic o_irq,
    input wire logic o_irq_oe
);
    import desi_pkg::*;
    logic rd_b;
    logic wr_b;
    logic wr_ctl;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // address decode shared by the properties
    assign rd_b = i_reg_rd && i_reg_addr == 8'hE6;
    assign wr_b = i_reg_wr && i_reg_addr == 8'hE6;
    assign wr_ctl = i_reg_wr && i_reg_addr == 8'hE0;
    sync_sets_a: assert property (i_b_sync_err ##1 rd_b |=> o_reg_rdata[7])
        else $error("sync flag not set");
    crc_sets_a: assert property (i_b_crc_err ##1 rd_b |=> o_reg_rdata[6])
        else $error("payload flag not set");
    flag_clear_a: assert property ((wr_b && i_reg_wdata[6] && !i_b_crc_err) ##1 rd_b
        |=> !o_reg_rdata[6]) else $error("flag not cleared");
    set_wins_a: assert property ((wr_b && i_b_crc_err) ##1 rd_b |=> o_reg_rdata[6])
        else $error("clear beat set");
    read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("no read answer");
    oe_on_a: assert property (wr_ctl && i_reg_wdata[0] |-> ##2 o_irq_oe)
        else $error("pin not driven");
    oe_off_a: assert property (wr_ctl && !i_reg_wdata[0] |-> ##2 !o_irq_oe)
        else $error("pin still driven");
    quiet_released_a: assert property (!o_irq_oe |-> !o_irq)
        else $error("irq without enable");
endmodule

// *** desi_error_irq_test.sv ***
`timescale 1ns/1ps
module desi_error_irq_test;
    import desi_pkg::*;
    typedef struct {logic [7:0] addr; logic [21:0] ev; desi_byte_t exp;} desi_row_s;
    desi_row_s rows[22];
    logic ref_clk, rst, reg_wr, reg_rd, locked, rvalid, irq, oe, pin;
    logic [7:0] addr;
    desi_byte_t wdata, rdata;
    logic [21:0] ev;
    int fails, checks_done, i, k;
    desi_error_irq u_desi_error_irq (.i_ref_clk(ref_clk), .i_rst(rst), .i_reg_addr(addr),
        .i_reg_wr(reg_wr), .i_reg_wdata(wdata), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_a_sync_err(ev[0]), .i_a_crc_err(ev[1]),
        .i_a_unc_ecc_err(ev[2]), .i_a_cor_ecc_err(ev[3]), .i_a_leader_err(ev[4]),
        .i_a_llp_err(ev[10:5]), .i_b_sync_err(ev[11]), .i_b_crc_err(ev[12]),
        .i_b_unc_ecc_err(ev[13]), .i_b_cor_ecc_err(ev[14]), .i_b_leader_err(ev[15]),
        .i_b_llp_err(ev[21:16]), .i_pll_locked(locked), .o_irq(irq), .o_irq_oe(oe));
    desi_host_model u_desi_host_model (.i_irq(irq), .i_irq_oe(oe), .o_pin(pin));
    task automatic check(input desi_byte_t seen, input desi_byte_t exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // host write: strobe for one edge, then one idle edge
    task automatic wr(input logic [7:0] a, input desi_byte_t d);
        addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    // host read with a bounded wait for the answer
    task automatic rd(input logic [7:0] a, input desi_byte_t exp);
        int n;
        addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge ref_clk);
        if (n == 4) begin
            fails++;
            print_verdict();
        end
        check(rdata, exp);
        @(negedge ref_clk);
    endtask
    task automatic pulse(input logic [21:0] v);
        ev = v;
        @(negedge ref_clk);
        ev = '0;
    endtask
    // error pulse with the read on the very next edge
    task automatic pulse_rd(input logic [21:0] v, input logic [7:0] a, input desi_byte_t exp);
        pulse(v);
        rd(a, exp);
    endtask
    // clearing write with the read on the very next edge
    task automatic wr_rd(input logic [7:0] a, input desi_byte_t d, input desi_byte_t exp);
        addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        rd(a, exp);
    endtask
    // free-running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // main sequence: reset values, one row per error source, then the odd cases
    initial begin
        {rst, reg_wr, reg_rd, locked, addr, wdata, ev} = {1'b1, 41'h0};
        for (i = 0; i < 22; i++) begin
            k = i % 11;
            rows[i] = '{i < 11 ? 8'hE5 : 8'hE6, 22'h1 << i, k < 4 ? 8'h80 >> k : k == 4 ? 8'h04 : 8'h08};
        end
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        rd(8'hE5, 8'h01);
        rd(8'hE6, 8'h00);
        rd(8'hE2, 8'h00);
        rd(8'hE3, 8'h00);
        wr(8'hE5, 8'h01);
        for (i = 0; i < 22; i++) begin
            pulse_rd(rows[i].ev, rows[i].addr, rows[i].exp);
            wr(rows[i].addr, ~rows[i].exp);
            rd(rows[i].addr, rows[i].exp);
            wr_rd(rows[i].addr, rows[i].exp, 8'h00);
        end
        locked = 1'b1;
        repeat (2) @(negedge ref_clk);
        locked = 1'b0;
        @(negedge ref_clk);
        rd(8'hE5, 8'h01);
        {addr, wdata, reg_wr, ev[12]} = {8'hE6, 8'h40, 2'b11};
        @(negedge ref_clk);
        {reg_wr, ev[12]} = 2'b00;
        rd(8'hE6, 8'h40);
        wr(8'hE0, 8'h01);
        wr(8'hE2, 8'h40);
        check({6'h0, oe, pin}, 8'h03);
        wr(8'hE2, 8'h00);
        check({6'h0, oe, pin}, 8'h02);
        wr(8'hE1, 8'h01);
        check({6'h0, oe, pin}, 8'h03);
        wr(8'hE1, 8'h00);
        check({6'h0, oe, pin}, 8'h02);
        wr(8'hE0, 8'h00);
        check({6'h0, oe, pin}, 8'h00);
        print_verdict();
    end
endmodule

bind desi_error_irq desi_error_irq_props u_desi_error_irq_props (.i_ref_clk, .i_rst,
    .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
    .i_b_sync_err, .i_b_crc_err, .o_irq, .o_irq_oe);
